/* File: src/itcs_pkg.sv */
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Acknowledge-action bit: zero sends ACK, one NACK.
// - Smart mode: data read performs acknowledge action.
// - Data register write performs no acknowledge action; in smart mode it sends the byte in a host read.
// - Command field is a strobe reading zero.
// - Command zero idle, command one reserved, ignored.
// - Finish command: acknowledge then await Start; in a host read, only await Start.
// - Response in host write: acknowledge, receive next.
// - Response after address in read: acknowledge, data flag.
// - Response after data in read: send byte.
// - Same-access acknowledge bit applies before command.
// - Byte done flag on byte end only; a collision does not set it.
// - Data access or command clears both flags.
// - Address flag on own address, Stop, or a collision on the NACK after an address.
// - Byte-done and address-match flags hold SCL low; stretch bit shows it.
// - Host acknowledge bit: zero ACK, one NACK.
// - Collision on lost high bit or NACK.
// - Collision clears by one or on Start.
// - Illegal Start/Stop sets flag; one clears it.
// - Illegal condition detection needs host section enabled.
// - Direction bit copies last address read/write bit.
// - Cause bit: zero Stop, one address.
// - Upper seven own-address bits match incoming address.
// - Own-address bit zero enables general call.
// - Smart read while held after address or received byte triggers acknowledge action.
// - Stop sets address flag only when enabled.
// - Accept-any-address mode matches every address.
package itcs_pkg;
	// Register indices; byte address is four times the index.
	localparam logic [7:0] IDX_HOST_CTRL = 8'h03;
	localparam logic [7:0] IDX_CTRL_MAIN = 8'h09;
	localparam logic [7:0] IDX_CMD_CTRL = 8'h0a;
	localparam logic [7:0] IDX_STATUS = 8'h0b;
	localparam logic [7:0] IDX_OWN_ADDR = 8'h0c;
	localparam logic [7:0] IDX_DATA = 8'h0d;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] CTRL_MAIN_MASK = 8'he7;
	localparam int BIT_HOST_ENABLE = 0;
	localparam int BIT_HALT_DETECT = 5;
	localparam int BIT_ACCEPT_ANY = 2;
	localparam int BIT_AUTO_ACK = 1;
	localparam int BIT_TARGET_ENABLE = 0;
	localparam int BIT_ACK_ACTION = 2;
	localparam int BIT_BYTE_DONE = 7;
	localparam int BIT_ADDR_HALT = 6;
	localparam int BIT_CONFLICT = 3;
	localparam int BIT_ILLEGAL = 2;
	localparam logic [1:0] CMD_IDLE = 2'h0;
	localparam logic [1:0] CMD_RESERVED = 2'h1;
	localparam logic [1:0] CMD_FINISH = 2'h2;
	localparam logic [1:0] CMD_RESPONSE = 2'h3;
	localparam logic [6:0] GENERAL_CALL = 7'h00;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [1:0] NEXT_IDLE = 2'h0;
	localparam logic [1:0] NEXT_RX = 2'h1;
	localparam logic [1:0] NEXT_TX_HOLD = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_HOLD_ADDR, ST_ACK_OUT, ST_RX, ST_HOLD_RX,
		ST_TX, ST_TX_ACK, ST_HOLD_TX
	} itcs_state_t;
	typedef struct packed {
		logic scl_s1;
		logic scl_s2;
		logic scl_q;
		logic sda_s1;
		logic sda_s2;
		logic sda_q;
		itcs_state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] data;
		logic [7:0] own;
		logic [7:0] ctl;
		logic ack_action_select;
		logic host_enable;
		logic byte_done_flag;
		logic addr_or_halt_flag;
		logic scl_stretch_active;
		logic host_ack_seen;
		logic drive_conflict_flag;
		logic illegal_condition_flag;
		logic direction;
		logic addr_or_halt_cause;
		logic sda_drive;
		logic nack_out;
		logic lost;
		logic fresh;
		logic in_xfer;
		logic from_addr;
		logic [1:0] ack_next;
	} itcs_regs_t;
	localparam itcs_regs_t RST_REGS = '{scl_s1: 1'b1, scl_s2: 1'b1,
		scl_q: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_q: 1'b1, st: ST_IDLE,
		default: '0};
endpackage : itcs_pkg

/* File: src/itcs_target.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module itcs_target (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	itcs_pkg::itcs_regs_t r_reg;
	itcs_pkg::itcs_regs_t r_next;
	logic acc_wr;
	logic acc_rd;
	logic cmd_wr;
	logic data_rd;
	logic data_wr;
	logic status_wr;
	logic flag_clear;
	logic ack_eff;
	logic go_ack;
	logic go_tx;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic mid_byte;
	logic addr_match;
	logic mapped;

	function automatic logic reg_hit(input logic [7:0] a,
		input logic [7:0] idx);
		reg_hit = (a[7:2] == idx[5:0]) && (a[1:0] == 2'h0);
	endfunction : reg_hit

	function automatic logic is_match(input logic [7:0] rx,
		input logic [7:0] own, input logic any);
		is_match = any || (rx[7:1] == own[7:1]) ||
			(own[0] && (rx[7:1] == itcs_pkg::GENERAL_CALL));
	endfunction : is_match

	////////////////////////////////////////////////////////////////////////
	// Bus slave decode; every access completes in its first access cycle.
	assign acc_wr = psel && penable && pwrite;
	assign acc_rd = psel && penable && !pwrite;
	assign cmd_wr = acc_wr && reg_hit(paddr, itcs_pkg::IDX_CMD_CTRL);
	assign data_rd = acc_rd && reg_hit(paddr, itcs_pkg::IDX_DATA);
	assign data_wr = acc_wr && reg_hit(paddr, itcs_pkg::IDX_DATA);
	assign status_wr = acc_wr && reg_hit(paddr, itcs_pkg::IDX_STATUS);
	assign flag_clear = cmd_wr || data_rd || data_wr;
	assign mapped = reg_hit(paddr, itcs_pkg::IDX_HOST_CTRL) ||
		reg_hit(paddr, itcs_pkg::IDX_CTRL_MAIN) ||
		reg_hit(paddr, itcs_pkg::IDX_CMD_CTRL) ||
		reg_hit(paddr, itcs_pkg::IDX_STATUS) ||
		reg_hit(paddr, itcs_pkg::IDX_OWN_ADDR) ||
		reg_hit(paddr, itcs_pkg::IDX_DATA);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// The bit written with the command is the one the command uses.
	assign ack_eff = cmd_wr ? pwdata[itcs_pkg::BIT_ACK_ACTION] :
		r_reg.ack_action_select;
	assign go_ack = ((r_reg.st == itcs_pkg::ST_HOLD_ADDR) ||
		(r_reg.st == itcs_pkg::ST_HOLD_RX)) &&
		((cmd_wr && pwdata[1]) ||
		(data_rd && r_reg.ctl[itcs_pkg::BIT_AUTO_ACK]));
	assign go_tx = (r_reg.st == itcs_pkg::ST_HOLD_TX) &&
		((cmd_wr && (pwdata[1:0] == itcs_pkg::CMD_RESPONSE)) ||
		(data_wr && r_reg.ctl[itcs_pkg::BIT_AUTO_ACK]));

	always_comb begin
		prdata = 32'h0000_0000;
		if (reg_hit(paddr, itcs_pkg::IDX_HOST_CTRL)) begin
			prdata[0] = r_reg.host_enable;
		end else if (reg_hit(paddr, itcs_pkg::IDX_CTRL_MAIN)) begin
			prdata[7:0] = r_reg.ctl;
		end else if (reg_hit(paddr, itcs_pkg::IDX_CMD_CTRL)) begin
			// The command strobe field always reads as zero.
			prdata[itcs_pkg::BIT_ACK_ACTION] = r_reg.ack_action_select;
		end else if (reg_hit(paddr, itcs_pkg::IDX_STATUS)) begin
			prdata[7:0] = {r_reg.byte_done_flag, r_reg.addr_or_halt_flag,
				r_reg.scl_stretch_active, r_reg.host_ack_seen,
				r_reg.drive_conflict_flag, r_reg.illegal_condition_flag,
				r_reg.direction, r_reg.addr_or_halt_cause};
		end else if (reg_hit(paddr, itcs_pkg::IDX_OWN_ADDR)) begin
			prdata[7:0] = r_reg.own;
		end else if (reg_hit(paddr, itcs_pkg::IDX_DATA)) begin
			prdata[7:0] = r_reg.data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus line conditions, seen only through the synchronised copies.
	assign scl_rise = r_reg.scl_s2 && !r_reg.scl_q;
	assign scl_fall = !r_reg.scl_s2 && r_reg.scl_q;
	assign start_c = r_reg.scl_s2 && r_reg.scl_q && r_reg.sda_q &&
		!r_reg.sda_s2 && r_reg.ctl[itcs_pkg::BIT_TARGET_ENABLE];
	assign stop_c = r_reg.scl_s2 && r_reg.scl_q && !r_reg.sda_q &&
		r_reg.sda_s2 && r_reg.ctl[itcs_pkg::BIT_TARGET_ENABLE];
	assign mid_byte = (r_reg.bitcnt != 4'h0) &&
		((r_reg.st == itcs_pkg::ST_ADDR) || (r_reg.st == itcs_pkg::ST_RX) ||
		(r_reg.st == itcs_pkg::ST_TX));
	assign addr_match = is_match(r_reg.shift, r_reg.own,
		r_reg.ctl[itcs_pkg::BIT_ACCEPT_ANY]);

	always_comb begin
		r_next = r_reg;
		r_next.scl_s1 = scl_i;
		r_next.scl_s2 = r_reg.scl_s1;
		r_next.scl_q = r_reg.scl_s2;
		r_next.sda_s1 = sda_i;
		r_next.sda_s2 = r_reg.sda_s1;
		r_next.sda_q = r_reg.sda_s2;
		// Software side first so that a bus event in the same cycle wins.
		if (acc_wr && reg_hit(paddr, itcs_pkg::IDX_HOST_CTRL)) begin
			r_next.host_enable = pwdata[itcs_pkg::BIT_HOST_ENABLE];
		end
		if (acc_wr && reg_hit(paddr, itcs_pkg::IDX_CTRL_MAIN)) begin
			r_next.ctl = pwdata[7:0] & itcs_pkg::CTRL_MAIN_MASK;
		end
		if (acc_wr && reg_hit(paddr, itcs_pkg::IDX_OWN_ADDR)) begin
			r_next.own = pwdata[7:0];
		end
		if (cmd_wr) begin
			r_next.ack_action_select = pwdata[itcs_pkg::BIT_ACK_ACTION];
		end
		if (data_wr) begin
			r_next.data = pwdata[7:0];
		end
		if (flag_clear) begin
			r_next.byte_done_flag = 1'b0;
			r_next.addr_or_halt_flag = 1'b0;
		end
		if (status_wr) begin
			if (pwdata[itcs_pkg::BIT_BYTE_DONE]) begin
				r_next.byte_done_flag = 1'b0;
			end
			if (pwdata[itcs_pkg::BIT_ADDR_HALT]) begin
				r_next.addr_or_halt_flag = 1'b0;
			end
			if (pwdata[itcs_pkg::BIT_CONFLICT]) begin
				r_next.drive_conflict_flag = 1'b0;
			end
			if (pwdata[itcs_pkg::BIT_ILLEGAL]) begin
				r_next.illegal_condition_flag = 1'b0;
			end
		end
		// Commands and smart-mode accesses while the clock is held.
		// Commands zero and one fall through and start no bus action.
		if (go_ack) begin
			r_next.sda_drive = !ack_eff;
			r_next.nack_out = ack_eff;
			r_next.scl_stretch_active = 1'b0;
			r_next.from_addr = (r_reg.st == itcs_pkg::ST_HOLD_ADDR);
			r_next.st = itcs_pkg::ST_ACK_OUT;
			if (ack_eff || (cmd_wr &&
				(pwdata[1:0] == itcs_pkg::CMD_FINISH))) begin
				r_next.ack_next = itcs_pkg::NEXT_IDLE;
			end else if ((r_reg.st == itcs_pkg::ST_HOLD_ADDR) &&
				r_reg.direction) begin
				r_next.ack_next = itcs_pkg::NEXT_TX_HOLD;
			end else begin
				r_next.ack_next = itcs_pkg::NEXT_RX;
			end
			if ((r_reg.st == itcs_pkg::ST_HOLD_ADDR) && r_reg.direction &&
				cmd_wr && (pwdata[1:0] == itcs_pkg::CMD_FINISH)) begin
				// Host read: finish only waits for the next Start.
				r_next.sda_drive = 1'b0;
				r_next.st = itcs_pkg::ST_IDLE;
			end
		end else if (go_tx) begin
			// A write of the data register alone performs no acknowledge.
			r_next.shift = data_wr ? pwdata[7:0] : r_reg.data;
			r_next.sda_drive = data_wr ? !pwdata[7] : !r_reg.data[7];
			r_next.bitcnt = 4'h0;
			r_next.lost = 1'b0;
			r_next.scl_stretch_active = 1'b0;
			r_next.st = itcs_pkg::ST_TX;
		end else if ((r_reg.st == itcs_pkg::ST_HOLD_TX) && cmd_wr &&
			(pwdata[1:0] == itcs_pkg::CMD_FINISH)) begin
			r_next.scl_stretch_active = 1'b0;
			r_next.st = itcs_pkg::ST_IDLE;
		end
		////////////////////////////////////////////////////////////////////
		// Bus side.
		case (r_reg.st)
			itcs_pkg::ST_IDLE: begin
			end
			itcs_pkg::ST_ADDR: begin
				if (scl_rise) begin
					r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
					r_next.bitcnt = r_reg.bitcnt + 4'h1;
					r_next.fresh = 1'b0;
				end else if (scl_fall &&
					(r_reg.bitcnt == itcs_pkg::BYTE_BITS)) begin
					r_next.bitcnt = 4'h0;
					if (addr_match) begin
						r_next.addr_or_halt_flag = 1'b1;
						r_next.addr_or_halt_cause = 1'b1;
						r_next.direction = r_reg.shift[0];
						r_next.scl_stretch_active = 1'b1;
						r_next.in_xfer = 1'b1;
						r_next.st = itcs_pkg::ST_HOLD_ADDR;
					end else begin
						r_next.st = itcs_pkg::ST_IDLE;
					end
				end
			end
			itcs_pkg::ST_ACK_OUT: begin
				if (scl_rise && r_reg.nack_out && !r_reg.sda_s2) begin
					r_next.drive_conflict_flag = 1'b1;
					r_next.addr_or_halt_flag = r_reg.from_addr ||
						r_next.addr_or_halt_flag;
				end else if (scl_fall) begin
					r_next.sda_drive = 1'b0;
					r_next.bitcnt = 4'h0;
					case (r_reg.ack_next)
						itcs_pkg::NEXT_RX: begin
							r_next.st = itcs_pkg::ST_RX;
						end
						itcs_pkg::NEXT_TX_HOLD: begin
							r_next.byte_done_flag = 1'b1;
							r_next.scl_stretch_active = 1'b1;
							r_next.st = itcs_pkg::ST_HOLD_TX;
						end
						default: begin
							r_next.st = itcs_pkg::ST_IDLE;
						end
					endcase
				end
			end
			itcs_pkg::ST_RX: begin
				if (scl_rise) begin
					r_next.shift = {r_reg.shift[6:0], r_reg.sda_s2};
					r_next.bitcnt = r_reg.bitcnt + 4'h1;
				end else if (scl_fall &&
					(r_reg.bitcnt == itcs_pkg::BYTE_BITS)) begin
					r_next.data = r_reg.shift;
					r_next.byte_done_flag = 1'b1;
					r_next.scl_stretch_active = 1'b1;
					r_next.st = itcs_pkg::ST_HOLD_RX;
				end
			end
			itcs_pkg::ST_TX: begin
				if (scl_rise) begin
					r_next.bitcnt = r_reg.bitcnt + 4'h1;
					if (!r_reg.sda_drive && !r_reg.sda_s2 && !r_reg.lost) begin
						// A released one read back low: stop driving the byte.
						r_next.drive_conflict_flag = 1'b1;
						r_next.lost = 1'b1;
					end
				end else if (scl_fall) begin
					if (r_reg.bitcnt == itcs_pkg::BYTE_BITS) begin
						r_next.sda_drive = 1'b0;
						r_next.st = itcs_pkg::ST_TX_ACK;
					end else begin
						r_next.shift = {r_reg.shift[6:0], 1'b0};
						r_next.sda_drive = !r_reg.lost && !r_reg.shift[6];
					end
				end
			end
			itcs_pkg::ST_TX_ACK: begin
				if (scl_rise) begin
					r_next.host_ack_seen = r_reg.sda_s2;
				end else if (scl_fall) begin
					r_next.bitcnt = 4'h0;
					r_next.byte_done_flag = 1'b1;
					r_next.scl_stretch_active = 1'b1;
					r_next.st = itcs_pkg::ST_HOLD_TX;
				end
			end
			itcs_pkg::ST_HOLD_ADDR, itcs_pkg::ST_HOLD_RX,
			itcs_pkg::ST_HOLD_TX: begin
			end
			default: begin
				r_next.st = itcs_pkg::ST_IDLE;
			end
		endcase
		if (start_c) begin
			if (r_reg.host_enable && mid_byte) begin
				r_next.illegal_condition_flag = 1'b1;
			end
			r_next.drive_conflict_flag = 1'b0;
			r_next.st = itcs_pkg::ST_ADDR;
			r_next.bitcnt = 4'h0;
			r_next.fresh = 1'b1;
			r_next.sda_drive = 1'b0;
			r_next.scl_stretch_active = 1'b0;
		end else if (stop_c) begin
			if (r_reg.host_enable && (r_reg.fresh || mid_byte)) begin
				r_next.illegal_condition_flag = 1'b1;
			end
			if (r_reg.ctl[itcs_pkg::BIT_HALT_DETECT] && r_reg.in_xfer) begin
				r_next.addr_or_halt_flag = 1'b1;
				r_next.addr_or_halt_cause = 1'b0;
			end
			r_next.in_xfer = 1'b0;
			r_next.fresh = 1'b0;
			r_next.st = itcs_pkg::ST_IDLE;
			r_next.sda_drive = 1'b0;
			r_next.scl_stretch_active = 1'b0;
		end
		if (!r_reg.ctl[itcs_pkg::BIT_TARGET_ENABLE]) begin
			r_next.st = itcs_pkg::ST_IDLE;
			r_next.sda_drive = 1'b0;
			r_next.scl_stretch_active = 1'b0;
			r_next.in_xfer = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= itcs_pkg::RST_REGS;
		end else begin
			r_reg <= r_next;
		end
	end

	// Both lines are only ever pulled low.
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = r_reg.scl_stretch_active;
	assign sda_oe = r_reg.sda_drive;

	////////////////////////////////////////////////////////////////////////
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_cmd_reads_zero: assert property (
		(acc_rd && reg_hit(paddr, itcs_pkg::IDX_CMD_CTRL)) |->
		(prdata[1:0] == 2'h0))
		else $error("command field read not zero");
	a_ack_level_out: assert property (
		(go_ack && !start_c && !stop_c && !(r_reg.direction &&
		(r_reg.st == itcs_pkg::ST_HOLD_ADDR) && cmd_wr && !pwdata[0])) |=>
		(sda_oe == !$past(ack_eff)) && !scl_oe)
		else $error("acknowledge level wrong");
	a_smart_read_ack: assert property (
		(data_rd && r_reg.ctl[itcs_pkg::BIT_AUTO_ACK] &&
		(r_reg.st == itcs_pkg::ST_HOLD_RX) && !start_c && !stop_c) |=>
		(r_reg.st == itcs_pkg::ST_ACK_OUT))
		else $error("smart read did not acknowledge");
	a_write_no_ack: assert property (
		(data_wr && (r_reg.st == itcs_pkg::ST_HOLD_TX) &&
		!r_reg.ctl[itcs_pkg::BIT_AUTO_ACK] && !start_c && !stop_c) |=>
		(r_reg.st == itcs_pkg::ST_HOLD_TX) && scl_oe)
		else $error("data write started a bus action");
	a_reserved_cmd_none: assert property (
		(cmd_wr && (pwdata[1:0] == itcs_pkg::CMD_RESERVED) &&
		r_reg.scl_stretch_active && !start_c && !stop_c) |=>
		scl_oe && $stable(r_reg.st))
		else $error("reserved command acted");
	a_finish_read_wait: assert property (
		(cmd_wr && (pwdata[1:0] == itcs_pkg::CMD_FINISH) &&
		(r_reg.st == itcs_pkg::ST_HOLD_TX) && !start_c) |=>
		(r_reg.st == itcs_pkg::ST_IDLE) && !scl_oe && !sda_oe)
		else $error("finish in read did not wait for start");
	a_flag_clear_access: assert property (
		(flag_clear && r_reg.scl_stretch_active && !status_wr) |=>
		!r_reg.byte_done_flag)
		else $error("flag not cleared by access");
	a_hold_on_flag: assert property (
		$rose(r_reg.byte_done_flag) |-> scl_oe ##0
		(prdata[5] || !reg_hit(paddr, itcs_pkg::IDX_STATUS)))
		else $error("clock not held on data flag");
	a_conflict_start_clr: assert property (
		start_c |=> !r_reg.drive_conflict_flag)
		else $error("collision kept across start");
	a_stop_gated_flag: assert property (
		(stop_c && !r_reg.ctl[itcs_pkg::BIT_HALT_DETECT]) |=>
		!$rose(r_reg.addr_or_halt_flag))
		else $error("stop flagged while disabled");
	a_dir_copy_addr: assert property (
		$rose(r_reg.st == itcs_pkg::ST_HOLD_ADDR) |->
		(r_reg.direction == r_reg.shift[0]) && r_reg.addr_or_halt_cause)
		else $error("direction not copied");

	c_addr_match: cover property ($rose(r_reg.st == itcs_pkg::ST_HOLD_ADDR));
	c_rx_byte: cover property ($rose(r_reg.st == itcs_pkg::ST_HOLD_RX));
	c_tx_byte: cover property (
		(r_reg.st == itcs_pkg::ST_TX_ACK) ##[1:200]
		(r_reg.st == itcs_pkg::ST_HOLD_TX));
	c_stop_flag: cover property (stop_c ##1 r_reg.addr_or_halt_flag);
endmodule : itcs_target

/* File: dv/itcs_host_model.sv */
`timescale 1ns/1ns
module itcs_host_model (
	output logic scl_low,
	output logic sda_low,
	input wire logic scl_line,
	input wire logic sda_line
);
	localparam int HALF = 80;
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Releases SCL and waits while the target stretches it.
	// A hold that never ends is caught by the bench watchdog.
	task automatic rise();
		scl_low = 1'b0;
		while (scl_line !== 1'b1)
			#10;
		#HALF;
	endtask : rise
	task automatic start();
		sda_low = 1'b1;
		#HALF;
		scl_low = 1'b1;
	endtask : start
	task automatic stop();
		#20;
		sda_low = 1'b1;
		#60;
		rise();
		sda_low = 1'b0;
		#HALF;
	endtask : stop
	task automatic put_bit(input logic b);
		#20;
		sda_low = ~b;
		#60;
		rise();
		scl_low = 1'b1;
	endtask : put_bit
	// A released SDA reads high through the pull-up.
	task automatic get_bit(output logic b);
		#20;
		sda_low = 1'b0;
		#60;
		rise();
		b = sda_line;
		scl_low = 1'b1;
	endtask : get_bit
	task automatic put_byte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--)
			put_bit(d[i]);
		get_bit(ack);
	endtask : put_byte
	task automatic get_byte(input logic nack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--)
			get_bit(d[i]);
		put_bit(nack);
	endtask : get_byte
endmodule : itcs_host_model

/* File: dv/tb_itcs_target.sv */
`timescale 1ns/1ns
module tb_itcs_target;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, err, ack;
	logic scl_low, sda_low, scl_line, sda_line;
	logic [7:0] v;
	int mismatches = 0;
	int n_compared = 0;
	assign scl_line = ~(scl_low | (scl_oe & ~scl_o));
	assign sda_line = ~(sda_low | (sda_oe & ~sda_o));
	always #10 pclk = ~pclk;
	itcs_target itcs_target_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe));
	itcs_host_model itcs_host_model_i (.scl_low(scl_low),
		.sda_low(sda_low), .scl_line(scl_line), .sda_line(sda_line));
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx[5:0], 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Later checks of pin levels then see this access's effect.
		@(negedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] junk;
		apb(1'b1, idx, d, junk);
	endtask : wr
	task automatic rd_cmp(input logic [7:0] idx, input logic [7:0] mask,
		input logic [7:0] exp);
		apb(1'b0, idx, 8'h00, v);
		cmp(v & mask, exp);
	endtask : rd_cmp
	task automatic wait_flag(input int b);
		int k;
		k = 0;
		v = 8'h00;
		while (v[b] !== 1'b1 && k < 500) begin
			apb(1'b0, itcs_pkg::IDX_STATUS, 8'h00, v);
			k++;
		end
		cmp(8'(v[b]), 8'h01);
	endtask : wait_flag
	// Lets a Stop settle, then clears a left-over byte-done or address flag with an idle command.
	task automatic settle(input string name);
		repeat (12) @(posedge pclk);
		wr(itcs_pkg::IDX_CMD_CTRL, 8'h00);
		$display("test %s done", name);
	endtask : settle
	////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		rd_cmp(itcs_pkg::IDX_STATUS, 8'hff, 8'h00);
		rd_cmp(itcs_pkg::IDX_OWN_ADDR, 8'hff, 8'h00);
		rd_cmp(itcs_pkg::IDX_DATA, 8'hff, 8'h00);
		wr(itcs_pkg::IDX_CMD_CTRL, 8'h04);
		rd_cmp(itcs_pkg::IDX_CMD_CTRL, 8'hff, 8'h04);
		wr(itcs_pkg::IDX_CMD_CTRL, 8'h00);
		apb(1'b0, 8'h0e, 8'h00, v);
		cmp(8'(err), 8'h01);
		wr(itcs_pkg::IDX_OWN_ADDR, 8'h55);
		wr(itcs_pkg::IDX_CTRL_MAIN, 8'h21);
		$display("test registers done");
		fork
			begin
				itcs_host_model_i.start();
				itcs_host_model_i.put_byte(8'h54, ack);
				cmp(8'(ack), 8'h00);
				itcs_host_model_i.put_byte(8'ha5, ack);
				cmp(8'(ack), 8'h00);
				itcs_host_model_i.stop();
			end
			begin
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'hff, 8'h61);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h03);
				wait_flag(itcs_pkg::BIT_BYTE_DONE);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h01);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'ha0, 8'h20);
				cmp(8'(scl_oe), 8'h01);
				rd_cmp(itcs_pkg::IDX_DATA, 8'hff, 8'ha5);
				cmp(8'(scl_oe), 8'h01);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h03);
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'h41, 8'h40);
			end
		join
		settle("host write");
		fork
			begin
				itcs_host_model_i.start();
				itcs_host_model_i.put_byte(8'h55, ack);
				cmp(8'(ack), 8'h00);
				itcs_host_model_i.get_byte(1'b1, v);
				cmp(v, 8'h3c);
				itcs_host_model_i.stop();
			end
			begin
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'hff, 8'h63);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h03);
				wait_flag(itcs_pkg::BIT_BYTE_DONE);
				wr(itcs_pkg::IDX_DATA, 8'h3c);
				cmp(8'(scl_oe), 8'h01);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h03);
				wait_flag(itcs_pkg::BIT_BYTE_DONE);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'h10, 8'h10);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h02);
			end
		join
		settle("host read");
		fork
			begin
				itcs_host_model_i.start();
				itcs_host_model_i.put_byte(8'h00, ack);
				cmp(8'(ack), 8'h01);
				itcs_host_model_i.stop();
			end
			begin
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h06);
			end
		join
		settle("general call");
		wr(itcs_pkg::IDX_OWN_ADDR, 8'h54);
		itcs_host_model_i.start();
		itcs_host_model_i.put_byte(8'h00, ack);
		cmp(8'(ack), 8'h01);
		itcs_host_model_i.stop();
		settle("general call off");
		wr(itcs_pkg::IDX_CTRL_MAIN, 8'h23);
		fork
			begin
				itcs_host_model_i.start();
				itcs_host_model_i.put_byte(8'h54, ack);
				itcs_host_model_i.put_byte(8'h11, ack);
				cmp(8'(ack), 8'h00);
				itcs_host_model_i.stop();
			end
			begin
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h03);
				wait_flag(itcs_pkg::BIT_BYTE_DONE);
				rd_cmp(itcs_pkg::IDX_DATA, 8'hff, 8'h11);
			end
		join
		settle("smart read");
		wr(itcs_pkg::IDX_CTRL_MAIN, 8'h25);
		fork
			begin
				itcs_host_model_i.start();
				itcs_host_model_i.put_byte(8'h3a, ack);
				cmp(8'(ack), 8'h00);
				itcs_host_model_i.stop();
			end
			begin
				wait_flag(itcs_pkg::BIT_ADDR_HALT);
				rd_cmp(itcs_pkg::IDX_STATUS, 8'hef, 8'h61);
				wr(itcs_pkg::IDX_CMD_CTRL, 8'h02);
			end
		join
		settle("any address");
		itcs_host_model_i.start();
		itcs_host_model_i.stop();
		repeat (12) @(posedge pclk);
		rd_cmp(itcs_pkg::IDX_STATUS, 8'h04, 8'h00);
		wr(itcs_pkg::IDX_HOST_CTRL, 8'h01);
		itcs_host_model_i.start();
		itcs_host_model_i.stop();
		repeat (12) @(posedge pclk);
		rd_cmp(itcs_pkg::IDX_STATUS, 8'h04, 8'h04);
		wr(itcs_pkg::IDX_STATUS, 8'h04);
		rd_cmp(itcs_pkg::IDX_STATUS, 8'h04, 8'h00);
		settle("illegal condition");
		stop_test();
	end
endmodule : tb_itcs_target
